// file: hw/radio_fe_pkg.sv
// Constants, register map and carrier types of the radio front-end control.
// Assumes a single 10 MHz clock and an AXI4-Lite master with 32-bit data.
// What this block and its host do
// RQ1 - Deviation equals step times fourteen-bit word
// RQ2 - Host keeps deviation plus half rate bounded
// RQ3 - Host programs deviation above the minimum
// RQ4 - On-off keying: amplifier on for ones
// RQ5 - FSK shaping selects one of three filters
// RQ6 - Pace each needed bit; host follows pacing
// RQ7 - Shaped on-off keying ramps bias smoothly
// RQ8 - Host restarts transmitter after shaping change
// RQ9 - Enables 100: first amplifier, -18 dBm base
// RQ10 - Enables 010: second amplifier, -18 dBm base
// RQ11 - Enables 011 normal: combined, -14 dBm base
// RQ12 - Enables 011 high power: -11 dBm base
// RQ13 - Host writes high-power tuning values
// RQ14 - Host restores tuning for receive, first amp
// RQ15 - Host adjusts or disables current limit
// RQ16 - Current clamp is 45 plus 5 per trim
// RQ17 - One bit selects 50 or 200 ohms
// RQ18 - Gain code zero lets gain loop choose
// RQ19 - Codes one to six force fixed gains
// RQ20 - Step is crystal over two to nineteen
// RQ21 - Host avoids reserved enable and gain codes
package radio_fe_pkg;
	localparam int ADDR_W = 10;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CURRENT_LIMIT = 8'h13;
	localparam logic [7:0] IDX_TUNE_A = 8'h5a;
	localparam logic [7:0] IDX_TUNE_B = 8'h5c;
	localparam logic [7:0] IDX_DEVIATION = 8'h40;
	localparam logic [7:0] IDX_BIT_RATE = 8'h41;
	localparam logic [7:0] IDX_SHAPING = 8'h42;
	localparam logic [7:0] IDX_AMP_LEVEL = 8'h43;
	localparam logic [7:0] IDX_RX_AMP = 8'h44;
	localparam logic [7:0] IDX_CONTROL = 8'h45;
	localparam logic [7:0] IDX_STATUS = 8'h46;
	// Reset values and the high-power tuning pair
	localparam logic [7:0] RST_CURRENT_LIMIT = 8'h1a;
	localparam logic [7:0] RST_TUNE_A = 8'h55;
	localparam logic [7:0] RST_TUNE_B = 8'h70;
	localparam logic [7:0] HP_TUNE_A = 8'h5d;
	localparam logic [7:0] HP_TUNE_B = 8'h7c;
	localparam logic [7:0] RST_AMP_LEVEL = 8'h9f;
	localparam logic [7:0] RST_RX_AMP = 8'h00;
	localparam logic [13:0] RST_DEVIATION = 14'h0052;
	localparam logic [15:0] RST_BIT_RATE = 16'h0008;
	localparam logic [2:0] RST_CONTROL = 3'h0;
	// Field positions
	localparam int AMP_A_BIT = 7;
	localparam int AMP_B_BIT = 6;
	localparam int AMP_C_BIT = 5;
	localparam int POWER_MSB = 4;
	localparam int OCP_EN_BIT = 4;
	localparam int OCP_TRIM_MSB = 3;
	localparam int ZIN_BIT = 7;
	localparam int CUR_GAIN_LSB = 3;
	localparam int GAIN_SEL_MSB = 2;
	localparam int CTRL_TX_EN = 0;
	localparam int CTRL_OOK = 1;
	localparam int CTRL_CONT = 2;
	// Output power bases in dBm
	localparam logic signed [6:0] BASE_SINGLE_DBM = -7'sh12;
	localparam logic signed [6:0] BASE_COMBINED_DBM = -7'sh0e;
	localparam logic signed [6:0] BASE_HIGH_DBM = -7'sh0b;
	// Current clamp in mA
	localparam logic [7:0] OCP_BASE_MA = 8'h2d;
	localparam logic [7:0] OCP_STEP_MA = 8'h05;
	// Receive gain
	localparam logic [2:0] GAIN_AUTO = 3'h0;
	localparam logic [2:0] GAIN_RESERVED = 3'h7;
	localparam logic [6:1][5:0] GAIN_ATTEN_DB =
		{6'h30, 6'h24, 6'h18, 6'h0c, 6'h06, 6'h00};
	// Shaping slew shifts, on-off ramp and bus response codes
	localparam logic [3:0] SLEW_SHIFT_BT1 = 4'h2;
	localparam logic [3:0] SLEW_SHIFT_BT05 = 4'h3;
	localparam logic [3:0] SLEW_SHIFT_BT03 = 4'h4;
	localparam logic [7:0] BIAS_FULL = 8'hff;
	localparam logic [7:0] BIAS_STEP = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		SHAPE_NONE = 2'b00,
		SHAPE_BT1 = 2'b01,
		SHAPE_BT05 = 2'b10,
		SHAPE_BT03 = 2'b11
	} shaping_t;

	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_RUN = 1'b1
	} tx_state_t;

	typedef struct packed {
		logic drive_a;
		logic drive_b;
		logic drive_c;
		logic reserved;
		logic high_power;
		logic signed [6:0] power_dbm;
	} amp_route_t;

	typedef struct packed {
		logic zin_200;
		logic reserved;
		logic [2:0] gain_step;
		logic [5:0] atten_db;
	} rx_front_t;
endpackage

// file: hw/radio_fe_ctrl.sv
// Transmit modulation, amplifier and receive front-end control with
// an AXI4-Lite register slave. Assumes one clock, synchronous inputs,
// and an external gain loop that reports its chosen step.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module radio_fe_ctrl
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [radio_fe_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [radio_fe_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Bit stream from the microcontroller
	input wire logic tx_data,
	output logic bit_pacing_clock,
	// Synthesizer and amplifiers
	output logic signed [14:0] divider_offset,
	output logic [7:0] amp_bias,
	output logic [2:0] amp_drive,
	output radio_fe_pkg::amp_route_t amp_route,
	output logic ocp_enable,
	output logic [7:0] current_limit_ma,
	// Receive front end
	input wire logic [2:0] agc_gain_step,
	output radio_fe_pkg::rx_front_t rx_front
);
	logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
	logic [radio_fe_pkg::ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r, rdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	logic [7:0] ocp_r, tune_a_r, tune_b_r, amp_level_r, rx_amp_r;
	logic [13:0] dev_r;
	logic [15:0] bit_rate_r;
	radio_fe_pkg::shaping_t shape_r;
	logic [2:0] ctrl_r;
	radio_fe_pkg::tx_state_t tx_state_r;
	logic [15:0] pace_cnt_r;
	logic pace_pulse_r, tx_bit_r;
	logic signed [14:0] freq_r, freq_nxt;
	logic [7:0] bias_r, bias_nxt;
	logic [2:0] drive_r;
	radio_fe_pkg::amp_route_t route_r, route_nxt;
	radio_fe_pkg::rx_front_t rx_r, rx_nxt;
	logic [7:0] ocp_ma_r;
	logic wr_go, pace_tick, gauss_cont, ook_mode, running;
	logic [7:0] wr_idx, rd_idx;
	logic [15:0] wmask, rd_cur16, wr_val;
	logic [31:0] rd_val, wr_view;
	logic rd_hit, wr_hit;

	assign s_axi_awready = !aw_hold_r && !bvalid_r;
	assign s_axi_wready = !w_hold_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
	assign wr_idx = awaddr_r[radio_fe_pkg::ADDR_W-1:2];
	assign rd_idx = s_axi_araddr[radio_fe_pkg::ADDR_W-1:2];
	assign wmask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

	// Register read view, shared by read mux and write merge
	function automatic logic [31:0] reg_view(input logic [7:0] idx);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (idx)
			radio_fe_pkg::IDX_CURRENT_LIMIT: v[7:0] = ocp_r;
			radio_fe_pkg::IDX_TUNE_A: v[7:0] = tune_a_r;
			radio_fe_pkg::IDX_TUNE_B: v[7:0] = tune_b_r;
			radio_fe_pkg::IDX_DEVIATION: v[13:0] = dev_r;
			radio_fe_pkg::IDX_BIT_RATE: v[15:0] = bit_rate_r;
			radio_fe_pkg::IDX_SHAPING: v[1:0] = shape_r;
			radio_fe_pkg::IDX_AMP_LEVEL: v[7:0] = amp_level_r;
			radio_fe_pkg::IDX_RX_AMP:
			begin
				v[7:0] = rx_amp_r;
				v[radio_fe_pkg::CUR_GAIN_LSB+:3] = rx_r.gain_step;
			end
			radio_fe_pkg::IDX_CONTROL: v[2:0] = ctrl_r;
			radio_fe_pkg::IDX_STATUS:
				v[11:0] = {rx_r.reserved, route_r.reserved, tx_bit_r,
					tx_state_r, bias_r};
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	function automatic logic is_mapped(input logic [7:0] idx);
		return idx == radio_fe_pkg::IDX_CURRENT_LIMIT ||
			idx == radio_fe_pkg::IDX_TUNE_A ||
			idx == radio_fe_pkg::IDX_TUNE_B ||
			(idx >= radio_fe_pkg::IDX_DEVIATION &&
			idx <= radio_fe_pkg::IDX_STATUS);
	endfunction

	// Procedural so the view follows the registers the function reads
	always_comb
	begin
		rd_val = reg_view(rd_idx);
		wr_view = reg_view(wr_idx);
	end
	assign rd_hit = is_mapped(rd_idx);
	assign wr_hit = is_mapped(wr_idx);
	assign rd_cur16 = wr_view[15:0];
	// Read-only bits come back from the live view, so they cannot stick
	assign wr_val = (rd_cur16 & ~wmask) | (wdata_r[15:0] & wmask);

	// Address and data may arrive in either order; each is held alone
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			else if (wr_go)
				aw_hold_r <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			else if (wr_go)
				w_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= radio_fe_pkg::RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_hit ? radio_fe_pkg::RESP_OKAY :
				radio_fe_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_r <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= radio_fe_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_val;
			rresp_r <= rd_hit ? radio_fe_pkg::RESP_OKAY :
				radio_fe_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_r <= 1'b0;
	end

	// Configuration registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ocp_r <= radio_fe_pkg::RST_CURRENT_LIMIT;
			tune_a_r <= radio_fe_pkg::RST_TUNE_A;
			tune_b_r <= radio_fe_pkg::RST_TUNE_B;
			dev_r <= radio_fe_pkg::RST_DEVIATION;
			bit_rate_r <= radio_fe_pkg::RST_BIT_RATE;
			shape_r <= radio_fe_pkg::SHAPE_NONE;
			amp_level_r <= radio_fe_pkg::RST_AMP_LEVEL;
			rx_amp_r <= radio_fe_pkg::RST_RX_AMP;
			ctrl_r <= radio_fe_pkg::RST_CONTROL;
		end
		else if (wr_go)
		begin
			unique case (wr_idx)
				radio_fe_pkg::IDX_CURRENT_LIMIT: ocp_r <= wr_val[7:0];
				radio_fe_pkg::IDX_TUNE_A: tune_a_r <= wr_val[7:0];
				radio_fe_pkg::IDX_TUNE_B: tune_b_r <= wr_val[7:0];
				radio_fe_pkg::IDX_DEVIATION: dev_r <= wr_val[13:0];
				radio_fe_pkg::IDX_BIT_RATE: bit_rate_r <= wr_val;
				radio_fe_pkg::IDX_SHAPING:
					shape_r <= radio_fe_pkg::shaping_t'(wr_val[1:0]);
				radio_fe_pkg::IDX_AMP_LEVEL: amp_level_r <= wr_val[7:0];
				radio_fe_pkg::IDX_RX_AMP:
					rx_amp_r <= {wr_val[7:6], 3'h0, wr_val[2:0]};
				radio_fe_pkg::IDX_CONTROL: ctrl_r <= wr_val[2:0];
				default: ;
			endcase
		end
	end

	assign ook_mode = ctrl_r[radio_fe_pkg::CTRL_OOK];
	assign running = tx_state_r == radio_fe_pkg::TX_RUN;
	assign gauss_cont = ctrl_r[radio_fe_pkg::CTRL_CONT] && !ook_mode &&
		shape_r != radio_fe_pkg::SHAPE_NONE;
	assign pace_tick = running && pace_cnt_r == 16'h0000;

	// Dropping the enable is the restart that clears the shaping state
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			tx_state_r <= radio_fe_pkg::TX_IDLE;
		else
			tx_state_r <= ctrl_r[radio_fe_pkg::CTRL_TX_EN] ?
				radio_fe_pkg::TX_RUN : radio_fe_pkg::TX_IDLE; // RQ8
	end

	// Bit pacing at bit_rate_r clocks per bit; zero acts as one
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pace_cnt_r <= 16'h0000;
			pace_pulse_r <= 1'b0;
			tx_bit_r <= 1'b0;
		end
		else
		begin
			if (!running || pace_cnt_r == 16'h0000)
				pace_cnt_r <= (bit_rate_r == 16'h0000) ? 16'h0000 :
					bit_rate_r - 16'h0001;
			else
				pace_cnt_r <= pace_cnt_r - 16'h0001;
			pace_pulse_r <= pace_tick && gauss_cont; // RQ6
			if (!ctrl_r[radio_fe_pkg::CTRL_CONT] || gauss_cont)
			begin
				if (pace_tick)
					tx_bit_r <= tx_data; // RQ6
			end
			else
				tx_bit_r <= tx_data;
		end
	end
	assign bit_pacing_clock = pace_pulse_r;

	// FSK: offset of plus or minus the word; shaping limits the slew
	always_comb
	begin
		logic signed [14:0] target;
		logic [13:0] slew;
		logic signed [15:0] diff, slew16, stepped;
		slew = 14'h0000;
		diff = 16'sh0000;
		slew16 = 16'sh0000;
		stepped = 16'sh0000;
		target = tx_bit_r ? $signed({1'b0, dev_r}) :
			-$signed({1'b0, dev_r}); // RQ1
		unique case (shape_r) // RQ5
			radio_fe_pkg::SHAPE_BT1: slew = dev_r >> radio_fe_pkg::SLEW_SHIFT_BT1;
			radio_fe_pkg::SHAPE_BT05: slew = dev_r >> radio_fe_pkg::SLEW_SHIFT_BT05;
			radio_fe_pkg::SHAPE_BT03: slew = dev_r >> radio_fe_pkg::SLEW_SHIFT_BT03;
			radio_fe_pkg::SHAPE_NONE: slew = dev_r;
		endcase
		if (slew == 14'h0000)
			slew = 14'h0001;
		slew16 = $signed({2'b00, slew});
		diff = $signed({target[14], target}) - $signed({freq_r[14], freq_r});
		if (diff > slew16)
			stepped = $signed({freq_r[14], freq_r}) + slew16;
		else if (diff < -slew16)
			stepped = $signed({freq_r[14], freq_r}) - slew16;
		else
			stepped = $signed({target[14], target});
		if (!running || ook_mode)
			freq_nxt = 15'sh0000;
		else if (shape_r == radio_fe_pkg::SHAPE_NONE)
			freq_nxt = target; // RQ1
		else
			freq_nxt = stepped[14:0]; // RQ5
	end

	// On-off keying bias: step, or ramp by BIAS_STEP when shaped
	always_comb
	begin
		bias_nxt = 8'h00;
		if (running && ook_mode)
		begin
			if (shape_r == radio_fe_pkg::SHAPE_NONE)
				bias_nxt = tx_bit_r ? radio_fe_pkg::BIAS_FULL : 8'h00; // RQ4
			else if (tx_bit_r)
				bias_nxt = (bias_r > radio_fe_pkg::BIAS_FULL -
					radio_fe_pkg::BIAS_STEP) ? radio_fe_pkg::BIAS_FULL :
					bias_r + radio_fe_pkg::BIAS_STEP; // RQ7
			else
				bias_nxt = (bias_r < radio_fe_pkg::BIAS_STEP) ? 8'h00 :
					bias_r - radio_fe_pkg::BIAS_STEP; // RQ7
		end
		else if (running)
			bias_nxt = radio_fe_pkg::BIAS_FULL;
	end

	// Amplifier selection and power; tuning pair marks high power
	always_comb
	begin
		logic [2:0] en;
		logic [6:0] lvl;
		en = amp_level_r[radio_fe_pkg::AMP_A_BIT:radio_fe_pkg::AMP_C_BIT];
		lvl = {2'b00, amp_level_r[radio_fe_pkg::POWER_MSB:0]};
		route_nxt = '0;
		route_nxt.high_power = tune_a_r == radio_fe_pkg::HP_TUNE_A &&
			tune_b_r == radio_fe_pkg::HP_TUNE_B;
		unique case (en)
			3'b100:
			begin
				route_nxt.drive_a = 1'b1; // RQ9
				route_nxt.power_dbm = radio_fe_pkg::BASE_SINGLE_DBM +
					$signed(lvl); // RQ9
			end
			3'b010:
			begin
				route_nxt.drive_b = 1'b1; // RQ10
				route_nxt.power_dbm = radio_fe_pkg::BASE_SINGLE_DBM +
					$signed(lvl); // RQ10
			end
			3'b011:
			begin
				route_nxt.drive_b = 1'b1; // RQ11
				route_nxt.drive_c = 1'b1; // RQ11
				route_nxt.power_dbm = (route_nxt.high_power ?
					radio_fe_pkg::BASE_HIGH_DBM :
					radio_fe_pkg::BASE_COMBINED_DBM) + $signed(lvl); // RQ12
			end
			default: route_nxt.reserved = 1'b1;
		endcase
	end

	// Receive front end: auto gain, forced steps, reserved holds max
	always_comb
	begin
		logic [2:0] sel;
		sel = rx_amp_r[radio_fe_pkg::GAIN_SEL_MSB:0];
		rx_nxt = '0;
		rx_nxt.zin_200 = rx_amp_r[radio_fe_pkg::ZIN_BIT]; // RQ17
		if (sel == radio_fe_pkg::GAIN_AUTO)
			rx_nxt.gain_step = agc_gain_step; // RQ18
		else if (sel == radio_fe_pkg::GAIN_RESERVED)
		begin
			rx_nxt.reserved = 1'b1;
			rx_nxt.gain_step = 3'h1;
		end
		else
			rx_nxt.gain_step = sel; // RQ19
		if (rx_nxt.gain_step == 3'h0 || rx_nxt.gain_step == 3'h7)
			rx_nxt.atten_db = 6'h00;
		else
			rx_nxt.atten_db = radio_fe_pkg::GAIN_ATTEN_DB[rx_nxt.gain_step];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			freq_r <= 15'sh0000;
			bias_r <= 8'h00;
			drive_r <= 3'h0;
			route_r <= '0;
			rx_r <= '0;
			ocp_ma_r <= radio_fe_pkg::OCP_BASE_MA;
		end
		else
		begin
			freq_r <= freq_nxt;
			bias_r <= bias_nxt;
			route_r <= route_nxt;
			rx_r <= rx_nxt;
			drive_r <= (running && bias_nxt != 8'h00) ?
				{route_nxt.drive_a, route_nxt.drive_b, route_nxt.drive_c} :
				3'h0; // RQ4
			ocp_ma_r <= radio_fe_pkg::OCP_BASE_MA + radio_fe_pkg::OCP_STEP_MA *
				{4'h0, ocp_r[radio_fe_pkg::OCP_TRIM_MSB:0]}; // RQ16
		end
	end

	// Offset counts synthesizer steps; the fraction is applied downstream
	assign divider_offset = freq_r; // RQ20
	assign amp_bias = bias_r;
	assign amp_drive = drive_r;
	assign amp_route = route_r;
	assign ocp_enable = ocp_r[radio_fe_pkg::OCP_EN_BIT];
	assign current_limit_ma = ocp_ma_r;
	assign rx_front = rx_r;

	property p_fsk_direct;
		@(posedge aclk) disable iff (!aresetn)
		(running && !ook_mode && shape_r == radio_fe_pkg::SHAPE_NONE &&
		ctrl_r[radio_fe_pkg::CTRL_TX_EN])
		|=> (freq_r == ($past(tx_bit_r) ? $signed({1'b0, $past(dev_r)}) :
		-$signed({1'b0, $past(dev_r)})));
	endproperty
	a_fsk_direct: assert property (p_fsk_direct) // RQ1
		else $error("fsk offset differs from deviation word");

	property p_shaped_slew;
		@(posedge aclk) disable iff (!aresetn)
		(running && !ook_mode && shape_r != radio_fe_pkg::SHAPE_NONE &&
		ctrl_r[radio_fe_pkg::CTRL_TX_EN] && $stable(shape_r))
		|=> ((freq_r - $past(freq_r)) <= $signed({2'b00, $past(dev_r)}) &&
		($past(freq_r) - freq_r) <= $signed({2'b00, $past(dev_r)}));
	endproperty
	a_shaped_slew: assert property (p_shaped_slew) // RQ5
		else $error("shaped offset jumped too far");

	property p_ook_step;
		@(posedge aclk) disable iff (!aresetn)
		(running && ook_mode && shape_r == radio_fe_pkg::SHAPE_NONE &&
		ctrl_r[radio_fe_pkg::CTRL_TX_EN])
		|=> (bias_r == ($past(tx_bit_r) ? radio_fe_pkg::BIAS_FULL : 8'h00));
	endproperty
	a_ook_step: assert property (p_ook_step) // RQ4
		else $error("unshaped keying bias wrong");

	sequence s_ook_shaped_one;
		running && ook_mode && tx_bit_r && ctrl_r[radio_fe_pkg::CTRL_TX_EN] &&
		shape_r != radio_fe_pkg::SHAPE_NONE;
	endsequence
	sequence s_bias_full;
		##[1:17] bias_r == radio_fe_pkg::BIAS_FULL;
	endsequence
	property p_ook_ramp;
		@(posedge aclk) disable iff (!aresetn)
		s_ook_shaped_one[*8] ##1 s_ook_shaped_one[*8] |-> s_bias_full;
	endproperty
	a_ook_ramp: assert property (p_ook_ramp) // RQ7
		else $error("shaped keying ramp did not reach full");

	property p_ook_smooth;
		@(posedge aclk) disable iff (!aresetn)
		s_ook_shaped_one |=> ({1'b0, bias_r} <= {1'b0, $past(bias_r)} +
		{1'b0, radio_fe_pkg::BIAS_STEP} && bias_r >= $past(bias_r));
	endproperty
	a_ook_smooth: assert property (p_ook_smooth) // RQ7
		else $error("shaped keying bias stepped");

	property p_pacing;
		@(posedge aclk) disable iff (!aresetn)
		(pace_tick && gauss_cont && ctrl_r[radio_fe_pkg::CTRL_TX_EN])
		|=> (bit_pacing_clock && tx_bit_r == $past(tx_data));
	endproperty
	a_pacing: assert property (p_pacing) // RQ6
		else $error("pacing pulse or bit capture missing");

	property p_amp_single;
		@(posedge aclk) disable iff (!aresetn)
		(amp_level_r[7:5] == 3'b100 || amp_level_r[7:5] == 3'b010)
		|=> (amp_route.drive_a == $past(amp_level_r[7]) && !amp_route.drive_c &&
		amp_route.power_dbm == -7'sh12 + $signed({2'b00, $past(amp_level_r[4:0])}));
	endproperty
	a_amp_single: assert property (p_amp_single) // RQ9 RQ10
		else $error("single amplifier power or route wrong");

	property p_amp_combined;
		@(posedge aclk) disable iff (!aresetn)
		(amp_level_r[7:5] == 3'b011) |=> (amp_route.drive_b && amp_route.drive_c &&
		amp_route.power_dbm == ($past(tune_a_r) == 8'h5d &&
		$past(tune_b_r) == 8'h7c ? -7'sh0b : -7'sh0e) +
		$signed({2'b00, $past(amp_level_r[4:0])}));
	endproperty
	a_amp_combined: assert property (p_amp_combined) // RQ11 RQ12
		else $error("combined amplifier power wrong");

	property p_ocp;
		@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> current_limit_ma == 8'h2d + 8'h05 * {4'h0, $past(ocp_r[3:0])};
	endproperty
	a_ocp: assert property (p_ocp) // RQ16
		else $error("current clamp value wrong");

	property p_rx_gain;
		@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> (rx_front.zin_200 == $past(rx_amp_r[7]) &&
		rx_front.gain_step == ($past(rx_amp_r[2:0]) == 3'h0 ?
		$past(agc_gain_step) : ($past(rx_amp_r[2:0]) == 3'h7 ? 3'h1 :
		$past(rx_amp_r[2:0]))));
	endproperty
	a_rx_gain: assert property (p_rx_gain) // RQ17 RQ18 RQ19
		else $error("receive gain or impedance wrong");
endmodule
`default_nettype wire

// file: test/bit_source.sv
// Companion controller model: streams random bits paced by the block.
// Assumes the pacing pulse is one aclk cycle wide.
`timescale 1ns/100ps
`default_nettype none
module bit_source
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pacing in, bench override
	input wire logic bit_pacing_clock,
	input wire logic hold_en,
	input wire logic hold_val,
	// Stream out
	output logic tx_data
);
	logic [7:0] st = 8'h5b;
	// New bit after the pulse, long before the next tick
	always @(posedge aclk)
		if (!aresetn)
			st <= 8'h5b;
		else if (bit_pacing_clock)
			st <= {st[6:0], st[7] ^ st[5] ^ st[4] ^ st[3]};
	assign tx_data = hold_en ? hold_val : st[0];
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the radio front-end control block.
// Assumes bit_source paces the stream and one 10 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, bry = 1'h0;
	logic arv = 1'h0, rry = 1'h0, hen = 1'h0, hv = 1'h0, fmon = 1'h0;
	logic omon = 1'h0, awr, wry, bv, arr, rv, bpc, txd, ocpe, prv;
	logic [9:0] awa = 10'h0, ara = 10'h0;
	logic [31:0] wd = 32'h0, rdat, d, rs = 32'h711951bb;
	logic [1:0] bresp, rresp, r;
	logic signed [14:0] dofs, dp, dn;
	logic signed [6:0] pw;
	logic [7:0] bias, lim, pb, o;
	logic [2:0] drv, g, s, agc = 3'h1;
	radio_fe_pkg::amp_route_t rte;
	radio_fe_pkg::rx_front_t rxf;
	int err_total = 0, checked = 0, npul = 0, gap = 0, k;
	logic [2:0] en [6] = '{3'h4, 3'h2, 3'h3, 3'h3, 3'h1, 3'h7};
	logic [5:0] at [8] = '{6'h0, 6'h0, 6'h6, 6'hc, 6'h18, 6'h24, 6'h30, 6'h0};
	logic [7:0] ix [3] = '{radio_fe_pkg::IDX_CURRENT_LIMIT,
		radio_fe_pkg::IDX_TUNE_A, radio_fe_pkg::IDX_TUNE_B};
	logic [7:0] iv [3] = '{radio_fe_pkg::RST_CURRENT_LIMIT,
		radio_fe_pkg::RST_TUNE_A, radio_fe_pkg::RST_TUNE_B};

	radio_fe_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wry),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rry), .tx_data(txd), .bit_pacing_clock(bpc),
		.divider_offset(dofs), .amp_bias(bias), .amp_drive(drv),
		.amp_route(rte), .ocp_enable(ocpe), .current_limit_ma(lim),
		.agc_gain_step(agc), .rx_front(rxf));
	bit_source src (.aclk(aclk), .aresetn(aresetn), .bit_pacing_clock(bpc),
		.hold_en(hen), .hold_val(hv), .tx_data(txd));

	initial
		forever #50 aclk = ~aclk;

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask

	// Ends at a falling edge so outputs are settled when compared
	task automatic settle(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask

	task automatic end_sim();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic stop_hang();
		err_total++;
		end_sim();
	endtask

	// Ready is looked at on the falling edge: nothing moves until the rise
	task automatic bus(input logic we, input logic [7:0] i,
		input logic [31:0] v);
		logic a, w;
		logic b = 1'h0;
		int n = 0;
		@(posedge aclk);
		awa <= {i, 2'h0};
		ara <= {i, 2'h0};
		wd <= v;
		awv <= we;
		wv <= we;
		arv <= !we;
		bry <= we;
		rry <= !we;
		while (!b && n < 50)
		begin
			@(negedge aclk);
			a = (awv && awr) || (arv && arr);
			w = wv && wry;
			b = we ? bv : rv;
			r = we ? bresp : rresp;
			d = rdat;
			@(posedge aclk);
			if (a)
			begin
				awv <= 1'h0;
				arv <= 1'h0;
			end
			if (w)
				wv <= 1'h0;
			n++;
		end
		bry <= 1'h0;
		rry <= 1'h0;
		if (!b)
			stop_hang();
	endtask

	always @(negedge aclk)
	begin
		if (omon)
			chk((bias >= pb ? bias - pb : pb - bias) <= 8'h10, 1'h1);
		pb = bias;
		if (fmon && bpc)
		begin
			if (npul > 0)
			begin
				chk(gap, 32'h30);
				chk(dofs, prv ? dp : dn);
			end
			npul++;
			gap = 1;
			prv = txd;
		end
		else
			gap++;
	end

	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		for (k = 0; k < 3; k++)
		begin
			bus(1'h0, ix[k], 32'h0);
			chk(d[7:0], iv[k]);
			rs = xs(rs);
			bus(1'h1, ix[k], rs);
			bus(1'h0, ix[k], 32'h0);
			chk(d[7:0], rs[7:0]);
		end
		bus(1'h1, 8'hff, rs);
		chk(r, radio_fe_pkg::RESP_SLVERR);
		bus(1'h0, 8'hff, 32'h0);
		chk({r, d[29:0]}, {radio_fe_pkg::RESP_SLVERR, 30'h0});
		for (k = 0; k < 6; k++)
		begin
			rs = xs(rs);
			o = (k == 3) ? 8'h0f : {4'h1, rs[11:8]};
			bus(1'h1, ix[0], o);
			bus(1'h1, ix[1], (k == 3) ? 32'h5d : 32'h55);
			bus(1'h1, ix[2], (k == 3) ? 32'h7c : 32'h70);
			bus(1'h1, radio_fe_pkg::IDX_AMP_LEVEL, {en[k], rs[4:0]});
			settle(2);
			chk(lim, 32'h2d + 32'h5 * o[3:0]);
			chk(ocpe, o[4]);
			// Reserved enable codes are sent on purpose: nothing may drive
			g = (en[k] == 3'h1 || en[k] == 3'h7) ? 3'h0 : en[k];
			chk(rte[11:8], {g, g == 3'h0});
			pw = (en[k] != 3'h3) ? -7'sh12 : (k == 3) ? -7'sh0b : -7'sh0e;
			pw = pw + {2'h0, rs[4:0]};
			if (g != 3'h0)
				chk(rte.power_dbm, pw);
		end
		for (k = 0; k < 8; k++)
		begin
			rs = xs(rs);
			g = rs[2:0] % 3'h6 + 3'h1;
			@(posedge aclk);
			agc <= g;
			bus(1'h1, radio_fe_pkg::IDX_RX_AMP, {rs[7], 4'h0, k[2:0]});
			settle(2);
			s = (k == 0) ? g : (k == 7) ? 3'h1 : k[2:0];
			chk(rxf, {rs[7], k == 7, s, at[s]});
		end
		rs = xs(rs);
		dp = {5'h0, rs[9:0]} + 15'h100;
		dn = -dp;
		bus(1'h1, radio_fe_pkg::IDX_DEVIATION, dp);
		bus(1'h1, radio_fe_pkg::IDX_BIT_RATE, 32'h30);
		// Shaping 0 is plain continuous FSK: no pacing, offset follows pin
		for (k = 0; k < 4; k++)
		begin
			bus(1'h1, radio_fe_pkg::IDX_CONTROL, 32'h0);
			bus(1'h1, radio_fe_pkg::IDX_SHAPING, k);
			bus(1'h1, radio_fe_pkg::IDX_CONTROL, 32'h5);
			npul = 0;
			fmon = 1'h1;
			settle(480);
			fmon = 1'h0;
			chk(npul > 8, k != 0);
			chk(npul == 0, k == 0);
			if (k == 0)
				chk(dofs, txd ? dp : dn);
		end
		bus(1'h1, radio_fe_pkg::IDX_AMP_LEVEL, 32'h9f);
		hen <= 1'h1;
		for (k = 0; k < 2; k++)
		begin
			bus(1'h1, radio_fe_pkg::IDX_CONTROL, 32'h0);
			bus(1'h1, radio_fe_pkg::IDX_SHAPING, k);
			hv <= 1'h1;
			bus(1'h1, radio_fe_pkg::IDX_CONTROL, 32'h3);
			omon = k[0];
			settle(120);
			chk({bias, drv}, {8'hff, 3'h4});
			@(posedge aclk);
			hv <= 1'h0;
			settle(120);
			chk({bias, drv}, 11'h0);
			omon = 1'h0;
		end
		end_sim();
	end
endmodule
`default_nettype wire
